// file: rtl/motor_ramp_defs.svh
// constants for the output-frequency ramp generator
// frequencies in 0.01 Hz, currents in A, times in 0.1 s, limits in percent
`ifndef MOTOR_RAMP_DEFS_SVH
`define MOTOR_RAMP_DEFS_SVH
`define CLOCK_PERIOD_NS 50
`define CTRL_TICK_NS 1000000
`define TENTH_SECOND_NS 100000000
`define PCT_SCALE 32'h00000064
`define SETTING_DISABLED 16'h270F
`define ZERO_START_FREQ 16'h0001
`define START_FREQ_MAX 16'h1770
`define HOLD_TIME_MAX 16'h0064
`define REF_CURRENT_MAX 16'h01F4
`define LIMIT_PCT_MAX 16'h00C8
`define LIMIT_PCT_DEFAULT 16'h0096
`define SHAPE_SEL_LINEAR 2'h0
`define SHAPE_SEL_S_A 2'h1
`define SHAPE_SEL_S_B 2'h2
`define AUTO_SHORTEST 4'h1
`define AUTO_SHORTEST_BRAKE 4'hB
`define AUTO_BRAKE_SEQ1 4'h7
`define AUTO_BRAKE_SEQ2 4'h8
`define DIRSEL_ACCEL_ONLY 2'h1
`define DIRSEL_DECEL_ONLY 2'h2
`define SB_JERK_SHIFT 4
`define SB_BRAKE_SHIFT 3
`define DIV_STEPS 6'h20
`define DIV_LATENCY 33
`endif

// file: rtl/motor_ramp_pkg.sv
// types shared by the ramp generator files
// no assumptions beyond the defs header
package motor_ramp_pkg;
    typedef enum logic [1:0] {ST_STOP, ST_HOLD, ST_RUN, ST_DECEL} drive_state_t;
    typedef enum logic [1:0] {SHAPE_LINEAR, SHAPE_S_A, SHAPE_S_B} ramp_shape_t;
endpackage

// file: rtl/ramp_div_if.sv
// request/answer bundle between ramp generator and its step divider
// one request at a time; requester starts every tick, engine ignores start while busy
`timescale 1ns/100ps
interface ramp_div_if;
    logic start;
    logic [31:0] dividend;
    logic [31:0] divisor;
    logic [31:0] quotient;
    logic done;
    modport requester (output start, output dividend, output divisor,
        input quotient, input done);
    modport engine (input start, input dividend, input divisor,
        output quotient, output done);
endinterface

// file: rtl/ramp_step_divider.sv
// serial restoring divider that yields the per-tick ramp increment
// assumes divisor is never zero and requests are spaced beyond its latency
`timescale 1ns/100ps
`include "motor_ramp_defs.svh"
module ramp_step_divider (
    input wire logic clock,
    input wire logic rst_b,
    ramp_div_if.engine dif
);
    logic [5:0] count_r;
    logic [31:0] rem_r;
    logic [31:0] quo_r;
    logic [31:0] dvs_r;
    logic [31:0] dvd_r;
    logic done_r;
    wire busy = count_r != 6'h00;
    wire [32:0] rem_sh = {rem_r, quo_r[31]};
    wire fits = rem_sh >= {1'b0, dvs_r};
    wire [32:0] rem_sub = rem_sh - {1'b0, dvs_r};
    wire [31:0] rem_next = fits ? rem_sub[31:0] : rem_sh[31:0];

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            count_r <= 6'h00;
            rem_r <= 32'h00000000;
            quo_r <= 32'h00000000;
            dvs_r <= 32'h00000001;
            dvd_r <= 32'h00000000;
            done_r <= 1'b0;
        end else if (dif.start && !busy) begin
            count_r <= `DIV_STEPS;
            rem_r <= 32'h00000000;
            quo_r <= dif.dividend;
            dvd_r <= dif.dividend;
            dvs_r <= dif.divisor;
            done_r <= 1'b0;
        end else begin
            done_r <= count_r == 6'h01;
            if (busy) begin
                count_r <= count_r - 6'h01;
                rem_r <= rem_next;
                quo_r <= {quo_r[30:0], fits};
            end
        end
    end

    assign dif.quotient = quo_r;
    assign dif.done = done_r;

    div_latency_a: assert property (@(posedge clock) disable iff (!rst_b) // RULE22
        dif.start && !busy |-> ##`DIV_LATENCY dif.done)
        else $error("step divider answer late or early");
    div_exact_a: assert property (@(posedge clock) disable iff (!rst_b) // RULE16
        dif.done |-> ({32'h00000000, quo_r} * {32'h00000000, dvs_r} <= {32'h00000000, dvd_r})
            && ({32'h00000000, quo_r} * {32'h00000000, dvs_r} + {32'h00000000, dvs_r}
            > {32'h00000000, dvd_r}))
        else $error("step divider quotient wrong");
endmodule // ramp_step_divider

// file: rtl/motor_frequency_ramp_control.sv
// output-frequency ramp generator with start hold, ramp shapes and shortest mode
// settings arrive as synchronous ports; output stage samples output_frequency
// Operation
// RULE1: stay stopped while frequency command is below the starting frequency
// RULE2: with hold enabled, output exactly starting frequency for the hold period
// RULE3: a zero starting frequency is replaced by 0.01 Hz during hold
// RULE4: start withdrawn during hold abandons hold and decelerates at once
// RULE5: on direction reversal apply starting frequency but skip hold
// RULE6: starting frequency at or below minimum runs at preset frequency on start alone
// RULE7: shape select 0 linear, 1 S-curve A, 2 S-curve B; linear after reset
// RULE8: linear shape changes frequency at a constant rate both ways
// RULE9: S-curve A inflects at base frequency, reduced slope at or above it
// RULE10: S-curve A ramp time is the time to reach base frequency
// RULE11: S-curve B shapes every change from present to target frequency
// RULE12: auto mode 0 normal, 1 and 11 shortest, 7 and 8 brake sequence
// RULE13: shortest direction 0 both, 1 acceleration only, 2 deceleration only
// RULE14: reference current 0 to 500 A; 9999 uses rated output current
// RULE15: accel and decel limits 0 to 200 percent; 9999 means 150 percent
// RULE16: shortest rate recomputed at each ramp start, settings left untouched
// RULE17: shortest ramp limit defaults to 150 percent; general level at constant speed
// RULE18: jog or second function while stopped reverts to normal ramping
// RULE19: jog and second function ignored while running in automatic mode
// RULE20: hold period 0.0 to 10.0 s; 9999 disables hold
// RULE21: starting frequency 0 to 60 Hz, output when start is asserted
// RULE22: output updated once per control tick by the shape-derived increment
`timescale 1ns/100ps
`include "motor_ramp_defs.svh"
module motor_frequency_ramp_control #(
    parameter int TICK_CYCLES = `CTRL_TICK_NS / `CLOCK_PERIOD_NS
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic start_command,
    input wire logic reverse_command,
    input wire logic jog_command,
    input wire logic second_function_select_input,
    input wire logic [15:0] frequency_command,
    input wire logic [15:0] starting_frequency_setting,
    input wire logic [15:0] start_hold_time_setting,
    input wire logic [1:0] ramp_shape_select,
    input wire logic [3:0] automatic_ramp_mode_select,
    input wire logic [1:0] shortest_mode_direction_select,
    input wire logic [15:0] shortest_mode_reference_current,
    input wire logic [15:0] shortest_accel_current_limit,
    input wire logic [15:0] shortest_decel_current_limit,
    input wire logic [15:0] acceleration_time_setting,
    input wire logic [15:0] deceleration_time_setting,
    input wire logic [15:0] minimum_frequency_setting,
    input wire logic [15:0] base_frequency_setting,
    input wire logic [15:0] ramp_reference_frequency,
    input wire logic [15:0] stall_prevention_level_setting,
    input wire logic [15:0] rated_output_current,
    input wire logic [15:0] output_current_measured,
    output logic [15:0] output_frequency,
    output logic output_reverse,
    output logic drive_running,
    output logic start_hold_active,
    output logic auto_ramp_active,
    output logic stall_limit_active,
    output logic brake_sequence_selected
);
    localparam int TICKS_PER_TENTH = `TENTH_SECOND_NS / `CTRL_TICK_NS;

    motor_ramp_pkg::drive_state_t state_r, state_nxt;
    logic [31:0] acc_r, acc_nxt;
    logic [15:0] tick_cnt_r;
    logic [15:0] hold_cnt_r, hold_cnt_nxt;
    logic dir_r, dir_nxt;
    logic rev_r, rev_nxt;
    logic [31:0] base_step_r;
    logic [31:0] sb_step_r;
    logic [1:0] ramp_dir_r;
    logic relatch_r;
    logic sb_restart_r;
    ramp_div_if dif ();

    ramp_step_divider u_div (
        .clock(clock),
        .rst_b(rst_b),
        .dif(dif)
    );

    // control tick
    wire tick = tick_cnt_r == 16'(TICK_CYCLES - 1);

    // setting ranges and sentinels
    wire [15:0] start_freq_c = (starting_frequency_setting > `START_FREQ_MAX) ?
        `START_FREQ_MAX : starting_frequency_setting; // RULE21
    wire [15:0] hold_freq = (start_freq_c == 16'h0000) ? `ZERO_START_FREQ : start_freq_c; // RULE3
    wire hold_enabled = start_hold_time_setting != `SETTING_DISABLED; // RULE20
    wire [15:0] hold_time_c = (start_hold_time_setting > `HOLD_TIME_MAX) ?
        `HOLD_TIME_MAX : start_hold_time_setting; // RULE20
    wire [15:0] hold_ticks = 16'(32'(hold_time_c) * 32'(TICKS_PER_TENTH));
    wire preset_run = start_freq_c <= minimum_frequency_setting; // RULE6
    wire start_ok = start_command &&
        (preset_run || frequency_command >= start_freq_c); // RULE1
    wire [15:0] run_target = (preset_run && frequency_command < minimum_frequency_setting) ?
        minimum_frequency_setting : frequency_command; // RULE6
    wire reversing = reverse_command != dir_r;

    // shape decode
    wire motor_ramp_pkg::ramp_shape_t shape =
        (ramp_shape_select == `SHAPE_SEL_S_A) ? motor_ramp_pkg::SHAPE_S_A :
        (ramp_shape_select == `SHAPE_SEL_S_B) ? motor_ramp_pkg::SHAPE_S_B :
        motor_ramp_pkg::SHAPE_LINEAR; // RULE7

    // target and ramp direction
    wire [15:0] present = acc_r[31:16];
    wire [15:0] target_freq = (state_r == motor_ramp_pkg::ST_RUN) ? run_target :
        (state_r == motor_ramp_pkg::ST_DECEL) ? 16'h0000 : present;
    wire [31:0] tgt_q = {target_freq, 16'h0000};
    wire accel = tgt_q > acc_r;
    wire decel = tgt_q < acc_r;
    wire ramp_start = {accel, decel} != ramp_dir_r;

    // automatic mode decode
    wire auto_sel = automatic_ramp_mode_select == `AUTO_SHORTEST ||
        automatic_ramp_mode_select == `AUTO_SHORTEST_BRAKE; // RULE12
    wire brake_mode = automatic_ramp_mode_select == `AUTO_SHORTEST_BRAKE; // RULE12
    wire brake_seq = automatic_ramp_mode_select == `AUTO_BRAKE_SEQ1 ||
        automatic_ramp_mode_select == `AUTO_BRAKE_SEQ2; // RULE12
    wire short_ramp = auto_ramp_active &&
        ((accel && shortest_mode_direction_select != `DIRSEL_DECEL_ONLY) ||
        (decel && shortest_mode_direction_select != `DIRSEL_ACCEL_ONLY)); // RULE13

    // stall limits
    wire [15:0] ref_current = (shortest_mode_reference_current == `SETTING_DISABLED) ?
        rated_output_current :
        (shortest_mode_reference_current > `REF_CURRENT_MAX) ? `REF_CURRENT_MAX :
        shortest_mode_reference_current; // RULE14
    wire [15:0] lim_raw = accel ? shortest_accel_current_limit : shortest_decel_current_limit;
    wire [15:0] lim_pct = (lim_raw == `SETTING_DISABLED) ? `LIMIT_PCT_DEFAULT :
        (lim_raw > `LIMIT_PCT_MAX) ? `LIMIT_PCT_MAX : lim_raw; // RULE15
    wire [31:0] meas_scaled = 32'(output_current_measured) * `PCT_SCALE;
    wire [31:0] ramp_limit = 32'(ref_current) * 32'(lim_pct); // RULE17
    wire [31:0] const_limit = 32'(rated_output_current) * 32'(stall_prevention_level_setting);
    wire over_limit = meas_scaled > ramp_limit; // RULE17
    wire over_const = meas_scaled > const_limit; // RULE17

    // divider request: full ramp in the set time
    wire [15:0] span_freq = (shape == motor_ramp_pkg::SHAPE_S_A) ?
        base_frequency_setting : ramp_reference_frequency; // RULE10
    wire [15:0] time_sel = decel ? deceleration_time_setting : acceleration_time_setting;
    wire [31:0] time_ticks = 32'(time_sel) * 32'(TICKS_PER_TENTH);
    assign dif.start = tick;
    assign dif.dividend = {span_freq, 16'h0000};
    assign dif.divisor = (time_ticks == 32'h00000000) ? 32'h00000001 : time_ticks;
    wire step_take = dif.done && (!short_ramp || relatch_r); // RULE16

    // shape steps
    wire [31:0] sa_step = (present >= base_frequency_setting) ?
        {1'b0, base_step_r[31:1]} : base_step_r; // RULE9
    wire [31:0] sb_inc = (base_step_r >> `SB_JERK_SHIFT) | 32'h00000001;
    wire [31:0] rem_q = accel ? (tgt_q - acc_r) : (acc_r - tgt_q);
    wire sb_brake = {3'b000, rem_q} <= {sb_step_r, 3'b000}; // RULE11
    wire [31:0] sb_up = (sb_step_r + sb_inc > base_step_r) ? base_step_r : sb_step_r + sb_inc;
    wire [31:0] sb_dn = (sb_step_r <= sb_inc + sb_inc) ? sb_inc : sb_step_r - sb_inc;
    wire [31:0] sb_nxt = (ramp_start || sb_restart_r) ? sb_inc : (sb_brake ? sb_dn : sb_up); // RULE11
    wire [31:0] short_step = over_limit ? 32'h00000000 :
        ((brake_mode && decel) ? (base_step_r << 2) : (base_step_r << 1)); // RULE16
    wire [31:0] eff_step = short_ramp ? short_step :
        (shape == motor_ramp_pkg::SHAPE_S_B) ? sb_step_r :
        (shape == motor_ramp_pkg::SHAPE_S_A) ? sa_step : base_step_r; // RULE8

    // one increment per tick, clipped at the target
    wire [32:0] up_sum = {1'b0, acc_r} + {1'b0, eff_step};
    wire [32:0] dn_diff = {1'b0, acc_r} - {1'b0, eff_step};
    wire [31:0] up_val = (up_sum > {1'b0, tgt_q}) ? tgt_q : up_sum[31:0];
    wire [31:0] dn_val = (dn_diff[32] || dn_diff[31:0] < tgt_q) ? tgt_q : dn_diff[31:0];
    wire [31:0] ramp_val = accel ? up_val : (decel ? dn_val : acc_r); // RULE22

    always_comb begin
        state_nxt = state_r;
        acc_nxt = acc_r;
        hold_cnt_nxt = hold_cnt_r;
        dir_nxt = dir_r;
        rev_nxt = rev_r;
        unique case (state_r)
            motor_ramp_pkg::ST_STOP: begin
                acc_nxt = 32'h00000000;
                hold_cnt_nxt = 16'h0000;
                rev_nxt = 1'b0;
                if (start_ok) begin // RULE1
                    dir_nxt = reverse_command;
                    if (hold_enabled) begin
                        state_nxt = motor_ramp_pkg::ST_HOLD; // RULE2
                        acc_nxt = {hold_freq, 16'h0000}; // RULE3
                    end else begin
                        state_nxt = motor_ramp_pkg::ST_RUN;
                        acc_nxt = {start_freq_c, 16'h0000}; // RULE21
                    end
                end
            end
            motor_ramp_pkg::ST_HOLD: begin
                if (!start_command || reversing) begin
                    state_nxt = motor_ramp_pkg::ST_DECEL; // RULE4
                    rev_nxt = start_command;
                end else if (tick) begin
                    if (hold_cnt_r >= hold_ticks) begin
                        state_nxt = motor_ramp_pkg::ST_RUN; // RULE2
                    end else begin
                        hold_cnt_nxt = hold_cnt_r + 16'h0001;
                    end
                end
            end
            motor_ramp_pkg::ST_RUN: begin
                if (!start_ok || reversing) begin
                    state_nxt = motor_ramp_pkg::ST_DECEL;
                    rev_nxt = start_ok && reversing;
                end else if (tick) begin
                    acc_nxt = ramp_val; // RULE22
                end
            end
            motor_ramp_pkg::ST_DECEL: begin
                if (start_ok && !rev_r && !reversing) begin
                    state_nxt = motor_ramp_pkg::ST_RUN;
                end else if (acc_r == 32'h00000000) begin
                    if (rev_r && start_ok) begin
                        state_nxt = motor_ramp_pkg::ST_RUN; // RULE5
                        dir_nxt = reverse_command;
                        rev_nxt = 1'b0;
                        acc_nxt = {start_freq_c, 16'h0000}; // RULE5
                    end else begin
                        state_nxt = motor_ramp_pkg::ST_STOP;
                    end
                end else if (tick) begin
                    acc_nxt = ramp_val;
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            tick_cnt_r <= 16'h0000;
        end else begin
            tick_cnt_r <= tick ? 16'h0000 : tick_cnt_r + 16'h0001;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= motor_ramp_pkg::ST_STOP;
            acc_r <= 32'h00000000;
            hold_cnt_r <= 16'h0000;
            dir_r <= 1'b0;
            rev_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            acc_r <= acc_nxt;
            hold_cnt_r <= hold_cnt_nxt;
            dir_r <= dir_nxt;
            rev_r <= rev_nxt;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            base_step_r <= 32'h00000000;
            sb_step_r <= 32'h00000001;
            ramp_dir_r <= 2'h0;
            relatch_r <= 1'b0;
            sb_restart_r <= 1'b0;
        end else begin
            ramp_dir_r <= {accel, decel};
            // ramp start seldom meets a tick: keep it until the next tick
            sb_restart_r <= (ramp_start || sb_restart_r) && !tick; // RULE11
            relatch_r <= ramp_start || (relatch_r && !step_take); // RULE16
            if (step_take) begin
                base_step_r <= dif.quotient; // RULE16
            end
            if (tick) begin
                sb_step_r <= sb_nxt; // RULE11
            end
        end
    end

    // automatic mode is chosen only while stopped
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            auto_ramp_active <= 1'b0;
        end else if (state_r == motor_ramp_pkg::ST_STOP) begin
            auto_ramp_active <= auto_sel && !jog_command &&
                !second_function_select_input; // RULE18
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            drive_running <= 1'b0;
            start_hold_active <= 1'b0;
            stall_limit_active <= 1'b0;
            brake_sequence_selected <= 1'b0;
        end else begin
            drive_running <= state_nxt != motor_ramp_pkg::ST_STOP;
            start_hold_active <= state_nxt == motor_ramp_pkg::ST_HOLD;
            stall_limit_active <= short_ramp ? over_limit : (!accel && !decel && over_const); // RULE17
            brake_sequence_selected <= brake_seq;
        end
    end

    assign output_frequency = acc_r[31:16];
    assign output_reverse = dir_r;

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);

    stop_below_start_a: assert property ( // RULE1
        state_r == motor_ramp_pkg::ST_STOP && !start_ok |=> output_frequency == 16'h0000
            && !drive_running)
        else $error("drive left stop below starting frequency");
    hold_entry_a: assert property ( // RULE2
        $rose(start_hold_active) |-> output_frequency == $past(hold_freq) && drive_running)
        else $error("hold does not output starting frequency");
    hold_steady_a: assert property ( // RULE2
        start_hold_active && $past(start_hold_active) |-> $stable(output_frequency))
        else $error("output moved during start hold");
    zero_start_a: assert property ( // RULE3
        $rose(start_hold_active) && $past(start_freq_c) == 16'h0000
            |-> output_frequency == `ZERO_START_FREQ)
        else $error("zero starting frequency not replaced");
    hold_abort_a: assert property ( // RULE4
        state_r == motor_ramp_pkg::ST_HOLD && !start_command
            |=> state_r == motor_ramp_pkg::ST_DECEL ##1 !start_hold_active)
        else $error("hold not abandoned on start withdrawal");
    reverse_nohold_a: assert property ( // RULE5
        state_r == motor_ramp_pkg::ST_DECEL && rev_r && acc_r == 32'h00000000 && start_ok
            |=> state_r == motor_ramp_pkg::ST_RUN && output_frequency == $past(start_freq_c)
            && output_reverse == $past(reverse_command))
        else $error("reversal restart wrong");
    preset_start_a: assert property ( // RULE6
        state_r == motor_ramp_pkg::ST_STOP && start_command && preset_run |=> drive_running)
        else $error("preset start did not run");
    linear_rate_a: assert property ( // RULE8
        tick && state_r == motor_ramp_pkg::ST_RUN && start_ok && !reversing && accel
            && !short_ramp && ramp_shape_select == `SHAPE_SEL_LINEAR && up_sum < {1'b0, tgt_q}
            |=> acc_r == $past(acc_r) + $past(base_step_r))
        else $error("linear increment not applied");
    stall_hold_a: assert property ( // RULE17
        tick && state_r == motor_ramp_pkg::ST_RUN && start_ok && !reversing && short_ramp
            && over_limit |=> acc_r == $past(acc_r) && stall_limit_active)
        else $error("shortest ramp moved over current limit");
    jog_revert_a: assert property ( // RULE18
        state_r == motor_ramp_pkg::ST_STOP && (jog_command || second_function_select_input)
            |=> !auto_ramp_active)
        else $error("automatic mode kept despite jog while stopped");
    jog_ignore_a: assert property ( // RULE19
        state_r != motor_ramp_pkg::ST_STOP |=> $stable(auto_ramp_active))
        else $error("automatic mode changed while running");
endmodule // motor_frequency_ramp_control

// file: verification/inverter_stage_model.sv
// stand-in for output stage and motor: load current follows output frequency
// assumes output_frequency in 0.01 Hz and current in A, one clock domain
`timescale 1ns/100ps
module inverter_stage_model (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [15:0] output_frequency,
    output logic [15:0] output_current_measured
);
    // magnetising current plus a part that grows with speed
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) output_current_measured <= 16'h0000;
        else output_current_measured <= 16'h0004 + (output_frequency >> 6);
    end
endmodule // inverter_stage_model

// file: verification/test_motor_frequency_ramp_control.sv
// self-checking bench for the output-frequency ramp generator
// assumes a 20-clock control tick and the output stage model
`timescale 1ns/100ps
module test_motor_frequency_ramp_control;
    localparam int TICK = 20;
    logic clock = 0, rst_b = 0, start_command = 0, jog_command = 0, sfs = 0;
    logic [15:0] freq_cmd = 16'h0000, start_freq = 16'h01F4, hold = 16'h270F;
    logic [15:0] acc_t = 16'h000A, dec_t = 16'h000A, min_f = 16'h0064, base_f = 16'h1770;
    logic [15:0] ref_f = 16'h1770, stall_lvl = 16'h0096, acc_lim = 16'h270F;
    logic rev = 0;
    logic [1:0] shape = 2'h0, dirsel = 2'h0;
    logic [3:0] auto_mode = 4'h0;
    logic [15:0] out_freq, cur, o1, o2, o3;
    logic out_rev, running, holding, auto_on, stall_on, brake_sel;
    int err_count = 0, checks_done = 0;
    always #25 clock = ~clock;
    motor_frequency_ramp_control #(.TICK_CYCLES(TICK)) motor_frequency_ramp_control_i (
        .clock(clock), .rst_b(rst_b), .start_command(start_command), .reverse_command(rev),
        .jog_command(jog_command), .second_function_select_input(sfs),
        .frequency_command(freq_cmd), .starting_frequency_setting(start_freq),
        .start_hold_time_setting(hold), .ramp_shape_select(shape),
        .automatic_ramp_mode_select(auto_mode), .shortest_mode_direction_select(dirsel),
        .shortest_mode_reference_current(16'h270F), .shortest_accel_current_limit(acc_lim),
        .shortest_decel_current_limit(16'h270F), .acceleration_time_setting(acc_t),
        .deceleration_time_setting(dec_t), .minimum_frequency_setting(min_f),
        .base_frequency_setting(base_f), .ramp_reference_frequency(ref_f),
        .stall_prevention_level_setting(stall_lvl), .rated_output_current(16'h0064),
        .output_current_measured(cur), .output_frequency(out_freq), .output_reverse(out_rev),
        .drive_running(running), .start_hold_active(holding), .auto_ramp_active(auto_on),
        .stall_limit_active(stall_on), .brake_sequence_selected(brake_sel));
    inverter_stage_model inverter_stage_model_i (.clock(clock), .rst_b(rst_b),
        .output_frequency(out_freq), .output_current_measured(cur));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic clk(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic go(input logic s);
        @(posedge clock);
        start_command <= s;
        clk(3);
    endtask
    task automatic wait_stop();
        for (int i = 0; i < 20000 && running !== 1'b0; i++) @(posedge clock);
        check(16'(running), 16'h0000);
    endtask
    task automatic t_refuse();
        freq_cmd <= 16'h0064;
        go(1'b1);
        check(16'(running), 16'h0000);
        go(1'b0);
    endtask
    task automatic t_zero_start();
        start_freq <= 16'h0000;
        hold <= 16'h0001;
        freq_cmd <= 16'h03E8;
        go(1'b1);
        check(16'(holding), 16'h0001);
        check(out_freq, 16'h0001);
        go(1'b0);
        check(16'(holding), 16'h0000);
        wait_stop();
    endtask
    task automatic t_hold_ramp();
        start_freq <= 16'h01F4;
        freq_cmd <= 16'h0BB8;
        go(1'b1);
        clk(1800);
        check(16'(holding), 16'h0001);
        check(out_freq, 16'h01F4);
        clk(500);
        check(16'(holding), 16'h0000);
        o1 = out_freq;
        clk(TICK);
        o2 = out_freq;
        clk(TICK);
        o3 = out_freq;
        // 6000 centi-Hz over 1000 ticks gives 6 per tick
        check(o2 - o1, 16'h0006);
        check(o3 - o2, 16'h0006);
        check(16'(stall_on), 16'h0000);
        go(1'b0);
        wait_stop();
    endtask
    task automatic t_auto_preset();
        start_freq <= 16'h0032;
        acc_lim <= 16'h0004;
        freq_cmd <= 16'h0000;
        hold <= 16'h270F;
        auto_mode <= 4'h1;
        jog_command <= 1'b1;
        clk(3);
        check(16'(auto_on), 16'h0000);
        jog_command <= 1'b0;
        go(1'b1);
        check(16'(auto_on), 16'h0001);
        check(16'(running), 16'h0001);
        sfs <= 1'b1;
        clk(3);
        check(16'(auto_on), 16'h0001);
        clk(200);
        check(16'(stall_on), 16'h0001);
        go(1'b0);
        wait_stop();
        sfs <= 1'b0;
        auto_mode <= 4'h7;
        clk(3);
        check(16'(brake_sel), 16'h0001);
    endtask
    task automatic t_reverse();
        auto_mode <= 4'h0;
        start_freq <= 16'h01F4;
        freq_cmd <= 16'h0258;
        hold <= 16'h0001;
        go(1'b1);
        check(16'(holding), 16'h0001);
        rev <= 1'b1;
        for (int i = 0; i < 4000 && out_rev !== 1'b1; i++) @(posedge clock);
        check(16'(out_rev), 16'h0001);
        check(16'(holding), 16'h0000);
        check(out_freq, 16'h01F4);
        stall_lvl <= 16'h000A;
        clk(500);
        // 13 A against 10 percent of 100 A at constant speed
        check(16'(stall_on), 16'h0001);
        stall_lvl <= 16'h0096;
        go(1'b0);
        wait_stop();
        rev <= 1'b0;
    endtask
    task automatic t_shape_a();
        shape <= 2'h1;
        base_f <= 16'h0BB8;
        acc_t <= 16'h0001;
        dec_t <= 16'h0001;
        hold <= 16'h270F;
        freq_cmd <= 16'h0FA0;
        go(1'b1);
        clk(100);
        o1 = out_freq;
        clk(TICK);
        o2 = out_freq;
        // 3000 centi-Hz over 100 ticks below the inflection point
        check(o2 - o1, 16'h001E);
        clk(2000);
        o1 = out_freq;
        clk(TICK);
        o2 = out_freq;
        check(o2 - o1, 16'h000F);
        go(1'b0);
        wait_stop();
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        clk(8);
        rst_b <= 1'b1;
        t_refuse();
        t_zero_start();
        t_hold_ramp();
        t_auto_preset();
        t_reverse();
        t_shape_a();
        finish_test();
    end
    initial begin
        clk(60000);
        err_count++;
        finish_test();
    end
endmodule // test_motor_frequency_ramp_control
